// ==== rtl/twi_evt_pkg.sv ====
// constants for the two-wire event, shortcut and interrupt block
// assumes a 32-bit apb register bus with byte addresses
package twi_evt_pkg;
  localparam int unsigned NUM_EVT = 6;
  localparam int unsigned AW      = 12;
  // event index order inside the flag vector
  localparam int unsigned EV_STOPPED = 0;
  localparam int unsigned EV_RXD     = 1;
  localparam int unsigned EV_TXD     = 2;
  localparam int unsigned EV_ERROR   = 3;
  localparam int unsigned EV_BOUND   = 4;
  localparam int unsigned EV_PAUSED  = 5;
  // task trigger offsets
  localparam logic [AW-1:0] TASK_HALT_OFF   = 12'h014;
  localparam logic [AW-1:0] TASK_PAUSE_OFF  = 12'h01c;
  localparam logic [AW-1:0] TASK_RESUME_OFF = 12'h020;
  // event flag offsets, one word each, in event index order
  localparam logic [NUM_EVT*AW-1:0] EVT_OFFS = {
    12'h148, 12'h138, 12'h124, 12'h11c, 12'h108, 12'h104};
  localparam logic [AW-1:0] SHORTCUT_OFF = 12'h200;
  localparam logic [AW-1:0] IRQ_SET_OFF  = 12'h304;
  localparam logic [AW-1:0] IRQ_CLR_OFF  = 12'h308;
  // enable bit positions, in event index order
  localparam logic [NUM_EVT*5-1:0] EN_POS = {
    5'h12, 5'h0e, 5'h09, 5'h07, 5'h02, 5'h01};
  localparam int unsigned SC_PAUSE_BIT = 0;
  localparam int unsigned SC_HALT_BIT  = 1;
  localparam int unsigned TASK_BIT     = 0;
  localparam int unsigned FLAG_BIT     = 0;
  localparam logic [1:0]   SC_RESET    = 2'h0;
  localparam logic [NUM_EVT-1:0] EN_RESET = 6'h00;
endpackage

// ==== rtl/twi_evt_irq.sv ====
// event flags, shortcuts and interrupt enables of a two-wire master
// assumes the engine's event pulses and ack strobe run on pclk
// Operation
// - paused event only after read ack, if requested
// - paused flag set on pause, held till cleared
// - shortcut bits pause and halt, reset zero
// - set-write enables stopped interrupt, reads back
// - set-write enables byte received interrupt
// - set-write enables byte sent interrupt
// - set-write enables error interrupt
// - set-write enables byte boundary interrupt
// - set-write enables paused interrupt
// - byte boundary event before each byte
// - clear-write disables interrupt, mirrors enable state
// - resume task releases paused transfer
//
// Decided for this implementation: the APB register port.
module twi_evt_irq (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        stopped_event,
  input  wire logic        byte_received_event,
  input  wire logic        byte_sent_event,
  input  wire logic        error_event,
  input  wire logic        byte_boundary_event,
  input  wire logic        read_ack_done,
  output logic             pause_task,
  output logic             halt_task,
  output logic             resume_task,
  output logic             engine_paused,
  output logic             irq
);
  localparam int unsigned N = twi_evt_pkg::NUM_EVT;

  function automatic logic [4:0] en_pos(input int unsigned i);
    en_pos = twi_evt_pkg::EN_POS[i*5 +: 5];
  endfunction

  function automatic logic [31:0] pack_en(input logic [N-1:0] v);
    pack_en = 32'h0000_0000;
    for (int i = 0; i < N; i++) begin
      pack_en[en_pos(i)] = v[i];
    end
  endfunction

  function automatic logic [N-1:0] unpack_en(input logic [31:0] w);
    for (int i = 0; i < N; i++) begin
      unpack_en[i] = w[en_pos(i)];
    end
  endfunction

  logic [N-1:0] flag_reg;
  logic [N-1:0] flag_next;
  logic [N-1:0] en_reg;
  logic [N-1:0] en_next;
  logic [1:0]   sc_reg;
  logic [1:0]   sc_next;
  logic         pend_reg;
  logic         pend_next;
  logic         paused_reg;
  logic         paused_next;
  logic [31:0]  rdata_reg;
  logic [31:0]  rdata_next;

  // bus decode
  // a task word acts on bit 0 only and reads back as zero
  wire setup_ph = psel & ~penable;
  wire wr_acc   = psel & penable & pwrite;
  wire wbit     = pwdata[twi_evt_pkg::TASK_BIT];
  wire hit_halt = paddr == twi_evt_pkg::TASK_HALT_OFF;
  wire hit_pse  = paddr == twi_evt_pkg::TASK_PAUSE_OFF;
  wire hit_res  = paddr == twi_evt_pkg::TASK_RESUME_OFF;
  wire hit_sc   = paddr == twi_evt_pkg::SHORTCUT_OFF;
  wire hit_set  = paddr == twi_evt_pkg::IRQ_SET_OFF;
  wire hit_clr  = paddr == twi_evt_pkg::IRQ_CLR_OFF;
  logic [N-1:0] hit_evt;
  for (genvar g = 0; g < N; g++) begin : g_hit
    assign hit_evt[g] = paddr == twi_evt_pkg::EVT_OFFS[g*12 +: 12];
  end
  wire hit_task = hit_halt | hit_pse | hit_res;
  wire mapped   = hit_task | hit_sc | hit_set | hit_clr | (|hit_evt);

  // task triggers: software write, or boundary shortcut in the same cycle
  wire sw_pause  = wr_acc & hit_pse & wbit;
  wire sw_halt   = wr_acc & hit_halt & wbit;
  wire sc_pause  = byte_boundary_event & sc_reg[twi_evt_pkg::SC_PAUSE_BIT];
  wire sc_halt   = byte_boundary_event & sc_reg[twi_evt_pkg::SC_HALT_BIT];
  assign pause_task  = sw_pause | sc_pause;
  assign halt_task   = sw_halt | sc_halt;
  assign resume_task = wr_acc & hit_res & wbit;

  // paused event: ack of a read completes while a pause is pending
  wire paused_evt = read_ack_done & pend_reg;
  assign pend_next = paused_evt | halt_task ? 1'b0 :
                     pause_task ? 1'b1 : pend_reg;
  // resume releases the hold; a fresh pause event wins over it
  assign paused_next = paused_evt ? 1'b1 :
                       resume_task | halt_task ? 1'b0 : paused_reg;

  // event flags: hardware set wins over a write-one clear
  wire [N-1:0] evt_in = {paused_evt, byte_boundary_event, error_event,
                         byte_sent_event, byte_received_event,
                         stopped_event};
  for (genvar g = 0; g < N; g++) begin : g_flag
    wire clr = wr_acc & hit_evt[g] & pwdata[twi_evt_pkg::FLAG_BIT];
    assign flag_next[g] = evt_in[g] | (flag_reg[g] & ~clr);
  end

  wire [N-1:0] wr_en_bits = unpack_en(pwdata);
  wire [N-1:0] en_set = (wr_acc & hit_set) ? wr_en_bits : '0;
  wire [N-1:0] en_clr = (wr_acc & hit_clr) ? wr_en_bits : '0;
  // zero bits leave the enable alone; a one in either register acts
  assign en_next = (en_reg | en_set)
                   & ~en_clr;
  assign sc_next = (wr_acc & hit_sc) ? pwdata[1:0] : sc_reg;

  // read data captured in setup so the access phase needs no wait
  wire [31:0] evt_rd = {31'h0, |(hit_evt & flag_reg)};
  wire [31:0] en_rd  = pack_en(en_reg);
  assign rdata_next = ~(setup_ph & ~pwrite) ? rdata_reg :
                      (hit_set | hit_clr) ? en_rd :
                      hit_sc ? {30'h0, sc_reg} :
                      (|hit_evt) ? evt_rd : 32'h0000_0000;

  // every access completes at once; unmapped ones answer with an error
  assign prdata        = rdata_reg;
  assign pready        = 1'b1;
  assign pslverr       = psel & penable & ~mapped;
  assign engine_paused = paused_reg;
  assign irq           = |(flag_reg & en_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg   <= '0;
      en_reg     <= twi_evt_pkg::EN_RESET;
      sc_reg     <= twi_evt_pkg::SC_RESET;
      pend_reg   <= 1'b0;
      paused_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
    end else begin
      flag_reg   <= flag_next;
      en_reg     <= en_next;
      sc_reg     <= sc_next;
      pend_reg   <= pend_next;
      paused_reg <= paused_next;
      rdata_reg  <= rdata_next;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pause_needs_req: assert property (
    flag_next[twi_evt_pkg::EV_PAUSED] & ~flag_reg[twi_evt_pkg::EV_PAUSED]
    |-> read_ack_done & pend_reg)
    else $error("paused flag rose without pending pause and ack");

  a_pause_flag_sets: assert property (
    read_ack_done & pend_reg |=> flag_reg[twi_evt_pkg::EV_PAUSED]
    & engine_paused)
    else $error("paused flag or state not set after read ack");

  a_flag_holds: assert property (
    flag_reg[twi_evt_pkg::EV_PAUSED] & ~(wr_acc
    & hit_evt[twi_evt_pkg::EV_PAUSED]) |=> flag_reg[twi_evt_pkg::EV_PAUSED])
    else $error("paused flag dropped without a clear");

  a_short_pause: assert property (
    byte_boundary_event & sc_reg[twi_evt_pkg::SC_PAUSE_BIT] |-> pause_task)
    else $error("boundary shortcut did not trigger pause");

  a_short_halt: assert property (
    byte_boundary_event & sc_reg[twi_evt_pkg::SC_HALT_BIT]
    |-> halt_task ##1 ~pend_reg)
    else $error("boundary shortcut did not trigger halt");

  a_short_quiet: assert property (
    ~byte_boundary_event & ~(wr_acc & (hit_pse | hit_halt))
    |-> ~pause_task & ~halt_task)
    else $error("task fired without boundary or write");

  // each set-write bit turns on exactly its own event's enable
  a_set_enables: assert property (
    wr_acc & hit_set & pwdata[en_pos(twi_evt_pkg::EV_STOPPED)]
    |=> en_reg[twi_evt_pkg::EV_STOPPED])
    else $error("stopped enable not set by a set write");

  a_set_rx: assert property (
    wr_acc & hit_set & pwdata[en_pos(twi_evt_pkg::EV_RXD)]
    |=> en_reg[twi_evt_pkg::EV_RXD])
    else $error("byte received enable not set by a set write");

  a_set_tx: assert property (
    wr_acc & hit_set & pwdata[en_pos(twi_evt_pkg::EV_TXD)]
    |=> en_reg[twi_evt_pkg::EV_TXD])
    else $error("byte sent enable not set by a set write");

  a_set_error: assert property (
    wr_acc & hit_set & pwdata[en_pos(twi_evt_pkg::EV_ERROR)]
    |=> en_reg[twi_evt_pkg::EV_ERROR])
    else $error("error enable not set by a set write");

  a_set_bound: assert property (
    wr_acc & hit_set & pwdata[en_pos(twi_evt_pkg::EV_BOUND)]
    |=> en_reg[twi_evt_pkg::EV_BOUND])
    else $error("boundary enable not set by a set write");

  a_set_paused: assert property (
    wr_acc & hit_set & pwdata[en_pos(twi_evt_pkg::EV_PAUSED)]
    |=> en_reg[twi_evt_pkg::EV_PAUSED])
    else $error("paused enable not set by a set write");

  // read data was captured in setup, so it shows that cycle's enables
  a_read_stopped: assert property (
    psel & penable & ~pwrite & (hit_set | hit_clr)
    |-> prdata[en_pos(twi_evt_pkg::EV_STOPPED)]
    == $past(en_reg[twi_evt_pkg::EV_STOPPED]))
    else $error("stopped enable read back wrong");

  a_read_enables: assert property (
    psel & penable & ~pwrite & (hit_set | hit_clr)
    |-> prdata == pack_en($past(en_reg)))
    else $error("enable read back differs from enable state");

  a_set_zero_keeps: assert property (
    wr_acc & hit_set |=> en_reg == ($past(en_reg) | $past(wr_en_bits)))
    else $error("enable set write changed a bit written zero");

  a_clr_disables: assert property (
    wr_acc & hit_clr |=> (en_reg & $past(wr_en_bits)) == '0)
    else $error("enable clear write left a bit enabled");

  // bits written zero through the clear register stay as they were
  a_clr_keeps: assert property (
    wr_acc & hit_clr
    |=> (en_reg | $past(wr_en_bits)) == ($past(en_reg) | $past(wr_en_bits)))
    else $error("enable clear write changed a bit written zero");

  a_irq_level: assert property (
    (flag_reg & en_reg) != '0 |-> irq)
    else $error("irq low with enabled flag set");

  a_irq_masked: assert property (
    (flag_reg & en_reg) == '0 |-> ~irq)
    else $error("irq high with no enabled flag set");

  a_resume_release: assert property (
    engine_paused & resume_task & ~paused_evt |=> ~engine_paused)
    else $error("resume did not release paused state");

  a_paused_holds: assert property (
    engine_paused & ~resume_task & ~halt_task |=> engine_paused)
    else $error("paused state dropped without resume or halt");

  a_resume_only_write: assert property (
    resume_task |-> wr_acc & hit_res & wbit)
    else $error("resume task fired without a resume write");

  a_halt_clears: assert property (
    halt_task & ~paused_evt |=> ~engine_paused)
    else $error("halt did not clear paused state");

  // a pause request waits for the read ack unless a halt cancels it
  a_pend_sets: assert property (
    pause_task & ~halt_task & ~paused_evt |=> pend_reg)
    else $error("pause request not held pending");

  a_flag_clears: assert property (
    wr_acc & hit_evt[twi_evt_pkg::EV_PAUSED] & pwdata[twi_evt_pkg::FLAG_BIT]
    & ~paused_evt |=> ~flag_reg[twi_evt_pkg::EV_PAUSED])
    else $error("paused flag not cleared by a one write");

  a_bound_flag: assert property (
    byte_boundary_event |=> flag_reg[twi_evt_pkg::EV_BOUND])
    else $error("boundary event did not set its flag");

  a_event_flags: assert property (
    evt_in != '0 |=> (flag_reg & $past(evt_in)) == $past(evt_in))
    else $error("event pulse did not set its flag");

  a_sc_holds: assert property (
    ~(wr_acc & hit_sc) |=> sc_reg == $past(sc_reg))
    else $error("shortcut bits changed without a write");

  // only the two low bits are kept; the rest of the word reads zero
  a_sc_readback: assert property (
    psel & penable & ~pwrite & hit_sc
    |-> prdata == {30'h0, $past(sc_reg)})
    else $error("shortcut read back wrong");

  // main scenarios
  c_short_pause: cover property (
    byte_boundary_event & sc_reg[twi_evt_pkg::SC_PAUSE_BIT]
    ##[1:20] paused_evt);
  c_irq_fire: cover property ($rose(irq));
  c_resume: cover property (engine_paused ##[1:20] resume_task);
  c_short_halt: cover property (
    byte_boundary_event & sc_reg[twi_evt_pkg::SC_HALT_BIT]);
  c_sw_pause: cover property (
    wr_acc & hit_pse & wbit ##[1:20] paused_evt);
endmodule // twi_evt_irq

// ==== tb/twi_engine_model.sv ====
// behavioural two-wire engine: turns a bench request into one event pulse
// assumes fire and code change by non-blocking assignment after pclk rises
module twi_engine_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       fire,
  input  wire logic [2:0] code,
  output logic            stopped_event,
  output logic            byte_received_event,
  output logic            byte_sent_event,
  output logic            error_event,
  output logic            byte_boundary_event,
  output logic            read_ack_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] pulse_reg;
  // one registered cycle per cycle of fire, so a one-cycle request gives a one-cycle pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pulse_reg <= 6'h00;
    else          pulse_reg <= fire ? (6'h01 << code) : 6'h00;
  end
  assign stopped_event       = pulse_reg[0];
  assign byte_received_event = pulse_reg[1];
  assign byte_sent_event     = pulse_reg[2];
  assign error_event         = pulse_reg[3];
  assign byte_boundary_event = pulse_reg[4];
  assign read_ack_done       = pulse_reg[5];
endmodule // twi_engine_model

// ==== tb/two_wire_event_irq_shortcuts_bench.sv ====
// self-checking bench: apb master, engine model and reference model
// assumes an apb slave that may stretch the access phase, and a 25 MHz pclk
module two_wire_event_irq_shortcuts_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, d, en, enm;
  logic [2:0] code = 3'h0;
  logic pready, pslverr, err, pause_task, halt_task, resume_task;
  logic [2:0] tk;
  logic engine_paused, irq, stp, rxd, txd, erv, bnd, ack;
  int bad_count, samples_checked, seed, fl[6], sc, pend, pz;
  always #20 pclk = ~pclk;
  twi_evt_irq DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stopped_event(stp), .byte_received_event(rxd), .byte_sent_event(txd),
    .error_event(erv), .byte_boundary_event(bnd), .read_ack_done(ack),
    .pause_task(pause_task), .halt_task(halt_task),
    .resume_task(resume_task), .engine_paused(engine_paused), .irq(irq));
  twi_engine_model engine (.pclk(pclk), .presetn(presetn), .fire(fire),
    .code(code), .stopped_event(stp), .byte_received_event(rxd),
    .byte_sent_event(txd), .error_event(erv), .byte_boundary_event(bnd),
    .read_ack_done(ack));
  task final_report;
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    samples_checked++;
    if (seen !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= v;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    // the answer is taken at the edge where pready is seen high
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata; err = pslverr; tk = {pause_task, halt_task, resume_task};
    if (pready !== 1'b1) begin bad_count++; final_report(); end
    psel <= 0; penable <= 0;
  endtask
  function automatic logic exp_irq();
    exp_irq = 0;
    for (int i = 0; i < 6; i++)
      if (fl[i] && en[twi_evt_pkg::EN_POS[i*5 +: 5]]) exp_irq = 1;
  endfunction
  task pulse(input int c);
    @(posedge pclk);
    fire <= 1; code <= c[2:0];
    @(posedge pclk);
    fire <= 0;
    @(negedge pclk);
    chk("pause_task", pause_task, c == 4 && sc[0]);
    chk("halt_task", halt_task, c == 4 && sc[1]);
    if (c < 5) fl[c] = 1;
    if (c == 4 && sc[0]) pend = 1;
    if (c == 4 && sc[1]) begin pend = 0; pz = 0; end
    if (c == 5 && pend) begin fl[5] = 1; pz = 1; pend = 0; end
    @(negedge pclk);
    chk("engine_paused", engine_paused, pz);
    chk("irq", irq, exp_irq());
  endtask
  initial begin
    seed = 32'h0ee2cdff;
    en = 0; enm = 0; sc = 0; pend = 0; pz = 0;
    for (int i = 0; i < 6; i++) enm[twi_evt_pkg::EN_POS[i*5 +: 5]] = 1;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, twi_evt_pkg::SHORTCUT_OFF, 0); chk("sc reset", r, 0);
    apb(0, twi_evt_pkg::IRQ_SET_OFF, 0); chk("en reset", r, 0);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      d = 32'h1 << twi_evt_pkg::EN_POS[i*5 +: 5];
      d = d | ($random(seed) & ~enm);
      apb(1, twi_evt_pkg::IRQ_SET_OFF, d); en = en | (d & enm);
      apb(0, twi_evt_pkg::IRQ_SET_OFF, 0);
      chk("en set", r, en);
      apb(0, twi_evt_pkg::IRQ_CLR_OFF, 0); chk("en mirror", r, en);
    end
    d = $random(seed);
    apb(1, twi_evt_pkg::IRQ_CLR_OFF, d); en = en & ~(d & enm);
    apb(1, twi_evt_pkg::IRQ_SET_OFF, 0);
    apb(0, twi_evt_pkg::IRQ_SET_OFF, 0); chk("en clr", r, en);
    apb(1, twi_evt_pkg::IRQ_SET_OFF, enm); en = enm;
    $display("test enables done");
    for (int c = 0; c < 5; c++) begin
      pulse(c);
      apb(0, twi_evt_pkg::EVT_OFFS[c*12 +: 12], 0); chk("flag", r, 1);
      apb(1, twi_evt_pkg::EVT_OFFS[c*12 +: 12], 1); fl[c] = 0;
      @(negedge pclk); chk("irq clr", irq, exp_irq());
    end
    $display("test events done");
    for (int s = 0; s < 4; s++) begin
      sc = s;
      // upper bits are random: the register keeps only the two shortcuts
      d = $random(seed) & ~32'h3;
      apb(1, twi_evt_pkg::SHORTCUT_OFF, d | s);
      apb(0, twi_evt_pkg::SHORTCUT_OFF, 0); chk("sc", r, s);
      chk("sc err", err, 0);
      pulse(4);
      pulse(5);
      apb(0, twi_evt_pkg::EVT_OFFS[twi_evt_pkg::EV_PAUSED*12 +: 12], 0);
      chk("paused", r, fl[5]);
      apb(1, twi_evt_pkg::TASK_RESUME_OFF, 1); pz = 0;
      chk("resume", tk, 3'b001);
      @(negedge pclk); chk("resumed", engine_paused, 0);
      for (int i = 0; i < 6; i++) apb(1, twi_evt_pkg::EVT_OFFS[i*12 +: 12], 1);
      for (int i = 0; i < 6; i++) fl[i] = 0;
    end
    $display("test shortcuts done");
    apb(1, twi_evt_pkg::TASK_PAUSE_OFF, 1); pend = 1;
    chk("sw pause", tk, 3'b100);
    pulse(5);
    apb(1, twi_evt_pkg::TASK_HALT_OFF, 1); pz = 0;
    chk("sw halt", tk, 3'b010);
    @(negedge pclk); chk("halted", engine_paused, 0);
    d = 32'h1 << twi_evt_pkg::EN_POS[twi_evt_pkg::EV_PAUSED*5 +: 5];
    apb(1, twi_evt_pkg::IRQ_CLR_OFF, d); en = en & ~d;
    @(negedge pclk); chk("irq masked", irq, exp_irq());
    $display("test tasks done");
    @(posedge pclk); presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1; en = 0; sc = 0; pend = 0; pz = 0;
    for (int i = 0; i < 6; i++) fl[i] = 0;
    chk("irq rst", irq, 0);
    apb(0, twi_evt_pkg::SHORTCUT_OFF, 0); chk("sc rst", r, 0);
    apb(0, twi_evt_pkg::IRQ_CLR_OFF, 0); chk("en rst", r, 0);
    $display("test reset again done");
    apb(0, 12'h0f0, 0); chk("unmapped err", err, 1); chk("unmapped rd", r, 0);
    $display("test unmapped done");
    final_report();
  end
endmodule // two_wire_event_irq_shortcuts_bench
